// >>> rtl/gpt_consts.vh
// Purpose: constants for the general timer and free-running counter
// Assumes: 20 MHz clk, 16-bit host bus with byte addresses A[7:1]
// Notes:   offsets are byte addresses of 32-bit registers
`ifndef GPT_CONSTS_VH
`define GPT_CONSTS_VH

// register offsets (byte addresses)
`define TIMER_CFG_OFS      8'h8C
`define TIMER_CNT_OFS      8'h90
`define FREE_RUN_OFS       8'h94

// timer_configuration fields
`define RUN_EN_BIT         29
`define RUN_EN_HI_BIT      13
`define PRELOAD_RST        16'hFFFF
`define COUNT_RST          16'hFFFF

// clock rates and timing
`define CLK_KHZ            17'h04E20
`define FREE_RUN_KHZ       17'h061A8
`define CLK_PERIOD_NS      50
`define TICK_NS            1000
`define TICK_CYCLES        (`TICK_NS / `CLK_PERIOD_NS)
`define FREE_RUN_W         32

`endif

// >>> rtl/free_run_counter.v
// Purpose: 32-bit counter advancing at 25 MHz from a 20 MHz clock
// Assumes: clk at CLK_KHZ, single clock domain
// Notes:   adds one or two per clk so the long-term rate is exact
`timescale 1ns/1ps
`include "gpt_consts.vh"

module free_run_counter #(
    parameter WIDTH = `FREE_RUN_W
) (
    clk,
    rstn,
    count_q
);
    input  wire             clk;
    input  wire             rstn;
    output reg  [WIDTH-1:0] count_q;

    localparam [16:0] RATE = `FREE_RUN_KHZ;
    localparam [16:0] BASE = `CLK_KHZ;

    reg  [16:0] phase_q;
    wire [16:0] sum = phase_q + RATE;
    wire        two = (sum >= {BASE[15:0], 1'b0});

    ////////////////////////////////////////////////////////////////////////
    // phase accumulator and count; no gating by power state
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase_q <= 17'h00000;
            count_q <= {WIDTH{1'b0}};
        end else begin
            if (two) begin
                phase_q <= sum - {BASE[15:0], 1'b0};
                count_q <= count_q + {{(WIDTH-2){1'b0}}, 2'h2};
            end else begin
                phase_q <= sum - BASE;
                count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule

// >>> rtl/gpt_free_timer.v
// Purpose: general 16-bit timer and free-running 32-bit counter
// Assumes: asynchronous SRAM-like 16-bit host bus, held 3+ clocks
// Notes:   host pins pass two flip-flops; A[1]=1 selects high half
`timescale 1ns/1ps
`include "gpt_consts.vh"

module gpt_free_timer #(
    parameter TICK_CYCLES = `TICK_CYCLES
) (
    clk,
    rstn,
    cs_n,
    rd_n,
    wr_n,
    addr,
    data_in,
    data_out,
    data_oe_n,
    timer_irq
);
    input  wire        clk;
    input  wire        rstn;
    input  wire        cs_n;
    input  wire        rd_n;
    input  wire        wr_n;
    input  wire [7:1]  addr;
    input  wire [15:0] data_in;
    output reg  [15:0] data_out;
    output reg         data_oe_n;
    output reg         timer_irq;

    localparam integer TICK_LAST_I = TICK_CYCLES - 1;
    localparam [15:0]  TICK_LAST   = TICK_LAST_I[15:0];

    ////////////////////////////////////////////////////////////////////////
    // two-stage synchronisers for the host pins
    reg  [25:0] pin_s1_q;
    reg  [25:0] pin_s2_q;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_s1_q <= {3'h7, 23'h000000};
            pin_s2_q <= {3'h7, 23'h000000};
        end else begin
            pin_s1_q <= {cs_n, rd_n, wr_n, addr, data_in};
            pin_s2_q <= pin_s1_q;
        end
    end

    wire        cs_n_s = pin_s2_q[25];
    wire        rd_n_s = pin_s2_q[24];
    wire        wr_n_s = pin_s2_q[23];
    wire [7:1]  addr_s = pin_s2_q[22:16];
    wire [15:0] wdata  = pin_s2_q[15:0];
    wire [7:0]  word_ofs = {addr_s[7:2], 2'b00};
    wire        hi_half  = addr_s[1];

    ////////////////////////////////////////////////////////////////////////
    // strobe edge detection on synchronised levels
    reg  rd_act_q;
    reg  wr_act_q;
    wire rd_act   = !cs_n_s && !rd_n_s;
    wire wr_act   = !cs_n_s && !wr_n_s;
    wire rd_start = rd_act && !rd_act_q;
    wire wr_start = wr_act && !wr_act_q;

    ////////////////////////////////////////////////////////////////////////
    // strobe history for the edge detectors
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_act_q <= 1'b0;
            wr_act_q <= 1'b0;
        end else begin
            rd_act_q <= rd_act;
            wr_act_q <= wr_act;
        end
    end

    wire sel_cfg  = (word_ofs == `TIMER_CFG_OFS);
    wire sel_cnt  = (word_ofs == `TIMER_CNT_OFS);
    wire sel_free = (word_ofs == `FREE_RUN_OFS);

    wire wr_cfg_lo = wr_start && sel_cfg && !hi_half;
    wire wr_cfg_hi = wr_start && sel_cfg && hi_half;
    wire run_new   = wdata[`RUN_EN_HI_BIT];

    ////////////////////////////////////////////////////////////////////////
    // free-running counter
    wire [31:0] free_count;

    free_run_counter #(
        .WIDTH (`FREE_RUN_W)
    ) i_free_run_counter (
        .clk     (clk),
        .rstn    (rstn),
        .count_q (free_count)
    );

    ////////////////////////////////////////////////////////////////////////
    // general timer
    reg         run_q;
    reg  [15:0] preload_q;
    reg  [15:0] count_q;
    reg  [15:0] tick_q;
    wire        tick = run_q && (tick_q == TICK_LAST);
    wire        load_now = wr_cfg_hi && !run_q && run_new;

    ////////////////////////////////////////////////////////////////////////
    // tick divider, cleared while halted
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tick_q <= 16'h0000;
        end else if (!run_q || tick) begin
            tick_q <= 16'h0000;
        end else begin
            tick_q <= tick_q + 16'h0001;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            run_q     <= 1'b0;
            preload_q <= `PRELOAD_RST;
            count_q   <= `COUNT_RST;
            timer_irq <= 1'b0;
        end else begin
            timer_irq <= 1'b0;
            if (wr_cfg_lo) begin
                preload_q <= wdata;
            end
            if (wr_cfg_hi) begin
                run_q <= run_new;
                if (run_q && !run_new) begin
                    preload_q <= `PRELOAD_RST;
                end
            end
            if (load_now) begin
                count_q <= preload_q;
            end else if (tick) begin
                if (count_q == 16'h0000) begin
                    count_q   <= preload_q;
                    timer_irq <= 1'b1;
                end else begin
                    count_q <= count_q - 16'h0001;
                end
            end
            // count_q holds while run_q is low, except for the load from preload_q on the write that sets run_q
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // free counter half-word snapshot
    reg  [31:0] snap_q;
    reg         snap_pend_q;
    reg         snap_hi_q;
    wire        rd_free  = rd_start && sel_free;
    wire        use_snap = snap_pend_q && (snap_hi_q != hi_half);

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            snap_q      <= 32'h00000000;
            snap_pend_q <= 1'b0;
            snap_hi_q   <= 1'b0;
        end else if (rd_free) begin
            if (use_snap) begin
                snap_pend_q <= 1'b0;
            end else begin
                snap_q      <= free_count;
                snap_pend_q <= 1'b1;
                snap_hi_q   <= hi_half;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data mux, unmapped and reserved bits read zero
    reg [15:0] rdata;
    reg [31:0] free_word;
    always @* begin
        rdata     = 16'h0000;
        free_word = use_snap ? snap_q : free_count;
        if (sel_cfg) begin
            if (hi_half) begin
                rdata = {2'b00, run_q, 13'h0000};
            end else begin
                rdata = preload_q;
            end
        end else if (sel_cnt) begin
            if (!hi_half) begin
                rdata = count_q;
            end
        end else if (sel_free) begin
            rdata = hi_half ? free_word[31:16] : free_word[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus output registers
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            data_out  <= 16'h0000;
            data_oe_n <= 1'b1;
        end else begin
            data_oe_n <= !rd_act;
            if (rd_start) begin
                data_out <= rdata;
            end
        end
    end
endmodule

// >>> test/gft_asserts.sv
// Purpose: port checks for gpt_free_timer
// Assumes: strobes low 3+ clocks
// Notes:   bound below
`timescale 1ns/1ps
module gft_asserts #(parameter TICK_CYCLES = 20) (
    input wire        clk,
    input wire        rstn,
    input wire        cs_n,
    input wire        rd_n,
    input wire        wr_n,
    input wire [7:1]  addr,
    input wire [15:0] data_in,
    input wire [15:0] data_out,
    input wire        data_oe_n,
    input wire        timer_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence rd_held; (!cs_n && !rd_n) [*3]; endsequence
    reset_quiet_a: assert property ($rose(rstn) |-> data_oe_n && !timer_irq)
        else $error("busy after reset");
    oe_start_a: assert property (rd_held |-> ##[0:2] !data_oe_n)
        else $error("read not answered");
    oe_cause_a: assert property ($fell(data_oe_n) |-> $past(!rd_n, 2))
        else $error("drive without read");
    oe_span_a: assert property ($fell(data_oe_n) |-> !data_oe_n [*2])
        else $error("drive too short");
    oe_release_a: assert property (rd_n [*5] |-> data_oe_n)
        else $error("bus not released");
    wr_quiet_a: assert property ((!cs_n && !wr_n) [*3] |-> data_oe_n)
        else $error("drive in write");
    out_change_a: assert property ($changed(data_out) |-> $fell(data_oe_n))
        else $error("data moved");
    irq_pulse_a: assert property (timer_irq && (TICK_CYCLES > 1)
        |=> !timer_irq) else $error("irq too long");
endmodule
bind gpt_free_timer gft_asserts #(.TICK_CYCLES(TICK_CYCLES)) i_gft_asserts (
    .clk(clk), .rstn(rstn), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .addr(addr), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .timer_irq(timer_irq));

// >>> test/host.sv
// Purpose: host cpu on the 16-bit bus
// Assumes: strobes low 5 clocks, high 4
// Notes:   idle data lines show inverted last value
`timescale 1ns/1ps
module host (
    input  wire        clk,
    input  wire [15:0] data_out,
    input  wire        data_oe_n,
    output reg         cs_n,
    output reg         rd_n,
    output reg         wr_n,
    output reg  [7:1]  addr,
    output wire [15:0] data_in
);
    reg [15:0] drv;
    assign data_in = data_oe_n ? drv : data_out;
    initial {cs_n, rd_n, wr_n, addr, drv} = {3'h7, 7'h00, 16'h0000};
    task acc(input w, input [7:0] a, input [15:0] d, output [15:0] q);
        @(negedge clk);
        addr = a[7:1];
        drv = w ? d : ~drv;
        {cs_n, rd_n, wr_n} = {1'b0, w, !w};
        repeat (5) @(posedge clk);
        @(negedge clk);
        q = data_out;
        {cs_n, rd_n, wr_n, drv} = {3'h7, ~drv};
        repeat (3) @(negedge clk);
    endtask
endmodule

// >>> test/gpt_free_timer_tb_top.sv
// Purpose: self-checking bench for gpt_free_timer
// Assumes: TICK_CYCLES of 2
// Notes:   free counter judged against elapsed clocks
`timescale 1ns/1ps
module gpt_free_timer_tb_top;
    reg         clk = 1'b0, rstn = 1'b0;
    wire        cs_n, rd_n, wr_n, data_oe_n, timer_irq;
    wire [7:1]  addr;
    wire [15:0] data_in, data_out;
    reg  [15:0] q, c;
    reg  [31:0] v1, v2;
    integer     t1, irqs = 0, cyc = 0, checks = 0, err_total = 0;
    gpt_free_timer #(.TICK_CYCLES(2)) i_gpt_free_timer (.clk(clk),
        .rstn(rstn), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
        .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
        .timer_irq(timer_irq));
    host i_host (.clk(clk), .data_out(data_out), .data_oe_n(data_oe_n),
        .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(data_in));
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc = cyc + 1;
        irqs = irqs + (timer_irq === 1'b1);
        err_total = err_total + (cyc == 3000);
        if (cyc == 3000) conclude;
    end
    task cmp(input [63:0] n, input [31:0] lo, hi, got);
        checks = checks + 1;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            err_total = err_total + 1;
            $display("CHECK FAILED %0s exp %h-%h got %h", n, lo, hi, got);
        end
    endtask
    task rd(input [63:0] n, input [7:0] a, input [15:0] e);
        i_host.acc(1'b0, a, 16'h0000, q);
        cmp(n, e, e, q);
    endtask
    task conclude;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        rd("cfg_lo", 8'h8C, 16'hFFFF);
        rd("cfg_hi", 8'h8E, 16'h0000);
        rd("cnt_lo", 8'h90, 16'hFFFF);
        $display("test reset done");
        t1 = cyc;
        i_host.acc(1'b0, 8'h96, 16'h0000, v1[31:16]);
        i_host.acc(1'b0, 8'h94, 16'h0000, v1[15:0]);
        repeat (200) @(negedge clk);
        t1 = cyc - t1;
        i_host.acc(1'b0, 8'h94, 16'h0000, v2[15:0]);
        i_host.acc(1'b0, 8'h96, 16'h0000, v2[31:16]);
        cmp("fr_rate", t1*5/4 - 2, t1*5/4 + 2, v2 - v1);
        $display("test free counter done");
        i_host.acc(1'b1, 8'h8C, 16'h0003, q);
        rd("preload", 8'h8C, 16'h0003);
        i_host.acc(1'b1, 8'h8E, 16'h2000, q);
        irqs = 0;
        repeat (80) @(negedge clk);
        cmp("irq_cnt", 9, 11, irqs);
        i_host.acc(1'b0, 8'h90, 16'h0000, q);
        cmp("cnt_run", 0, 3, q);
        rd("run_on", 8'h8E, 16'h2000);
        i_host.acc(1'b1, 8'h8E, 16'h0000, q);
        rd("preset", 8'h8C, 16'hFFFF);
        i_host.acc(1'b0, 8'h90, 16'h0000, c);
        irqs = 0;
        i_host.acc(1'b1, 8'h90, 16'h1234, q);
        repeat (40) @(negedge clk);
        rd("cnt_halt", 8'h90, c);
        cmp("irq_halt", 0, 0, irqs);
        $display("test timer done");
        conclude;
    end
endmodule
